/* File: core_tick_timer.sv */
/*
 core tick timer: down-counting tick timer with control/status, reload and
 current-value registers, plus an interrupt status/mask pair, behind an
 AHB-Lite slave. assumes a single core clock, the core's debug halt level
 and the debugger's access marker on the same clock as the bus.
*/
// Design decision made here: the AHB-Lite interface to the registers.
// Operation
// - 24-bit down counter, decrements when enabled, wraps at zero, write clears.
// - counts to zero, reloads on next edge, keeps decrementing after.
// - reload of zero stops the counter at its next wrap.
// - control bit 16 reads 1 after a zero; a read clears it.
// - debugger reads clear the flag only when its master kind is 0.
// - any current-value write clears count and flag, no tick pend.
// - current-value read returns the count at the moment of access.
// - count holds while the core is halted for debug.
// - clock select bit 2 stored; counting always uses the core clock.
// - a reference clock must be at most core rate over 2.5.
// - tick enable bit 1 decides whether a zero pends the tick.
// - enable bit 0 loads reload and starts repeat countdown; clear stops.
// - reserved control bits read indeterminate; software never alters them.
// - only privileged accesses reach registers; user accesses get a fault.
// - byte, halfword and word accesses, always little endian.
// - reload register holds the 24-bit start value in bits 23:0.
// - reload N gives one zero event every N+1 counting clocks.
`timescale 1ns/1ps
`default_nettype none
module core_tick_timer #(
  parameter int COUNT_W = core_tick_timer_pkg::COUNT_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic dbg_access,
  input wire logic debug_master_kind,
  input wire logic core_halted,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic tick_pend,
  output logic irq
);
  localparam logic [COUNT_W-1:0] COUNT_ZERO = '0;
  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  core_tick_timer_pkg::resp_state_t rsp_state;
  logic acc_valid;
  logic take;
  logic [31:0] acc_word;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [3:0] wr_strb;
  logic [31:0] read_word;
  logic [31:0] ctrl_word;
  logic [31:0] wr_ctrl_word;
  logic [31:0] wr_reload_word;
  logic wr_ctrl;
  logic wr_cur;
  logic rd_ctrl_clear;
  logic enable;
  logic tick_irq_enable;
  logic clock_select_bit;
  logic enable_rise;
  logic counting;
  logic zero_event;
  logic zero_reached_flag;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] reload;
  logic irq_status;
  logic irq_mask;
  logic next_irq_status;

  assign acc_valid = hsel && hready &&
                     htrans[core_tick_timer_pkg::HTRANS_ACTIVE_BIT];
  assign take = acc_valid && hprot[core_tick_timer_pkg::HPROT_PRIV_BIT];
  assign acc_word = {haddr[31:2], 2'b00};

  // bus response: unprivileged accesses take the two-cycle error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_state <= core_tick_timer_pkg::RSP_OKAY;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      case (rsp_state)
        core_tick_timer_pkg::RSP_ERR_WAIT: begin
          rsp_state <= core_tick_timer_pkg::RSP_ERR_DONE;
          hreadyout <= 1'b1;
          hresp <= 1'b1;
        end
        default: begin
          if (acc_valid && !take) begin
            rsp_state <= core_tick_timer_pkg::RSP_ERR_WAIT;
            hreadyout <= 1'b0;
            hresp <= 1'b1;
          end else begin
            rsp_state <= core_tick_timer_pkg::RSP_OKAY;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
          end
        end
      endcase
    end
  end

  // write address phase held for the data phase, when hwdata arrives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= core_tick_timer_pkg::WORD_ZERO;
      wr_strb <= core_tick_timer_pkg::STRB_WORD;
    end else begin
      wr_pend <= take && hwrite;
      wr_addr <= acc_word;
      wr_strb <= core_tick_timer_pkg::lane_strobes(hsize, haddr[1:0]);
    end
  end

  // reserved control bits read zero, a legal choice of indeterminate
  always_comb begin
    ctrl_word = core_tick_timer_pkg::WORD_ZERO;
    ctrl_word[core_tick_timer_pkg::CTRL_ENABLE_BIT] = enable;
    ctrl_word[core_tick_timer_pkg::CTRL_IRQ_EN_BIT] = tick_irq_enable;
    ctrl_word[core_tick_timer_pkg::CTRL_CLKSEL_BIT] = clock_select_bit;
    ctrl_word[core_tick_timer_pkg::CTRL_FLAG_BIT] = zero_reached_flag;
  end

  always_comb begin
    read_word = core_tick_timer_pkg::WORD_ZERO;
    case (acc_word)
      core_tick_timer_pkg::CTRL_ADDR: read_word = ctrl_word;
      core_tick_timer_pkg::RELOAD_ADDR: read_word[COUNT_W-1:0] = reload;
      core_tick_timer_pkg::CURRENT_ADDR: read_word[COUNT_W-1:0] = count;
      core_tick_timer_pkg::IRQ_STATUS_ADDR:
        read_word[core_tick_timer_pkg::IRQ_ZERO_BIT] = irq_status;
      core_tick_timer_pkg::IRQ_MASK_ADDR:
        read_word[core_tick_timer_pkg::IRQ_ZERO_BIT] = irq_mask;
      default: read_word = core_tick_timer_pkg::WORD_ZERO;
    endcase
  end

  // sampled at the address phase edge: the count as it stands then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= core_tick_timer_pkg::WORD_ZERO;
    end else if (take && !hwrite) begin
      hrdata <= read_word;
    end else begin
      hrdata <= core_tick_timer_pkg::WORD_ZERO;
    end
  end

  assign wr_ctrl = wr_pend && (wr_addr == core_tick_timer_pkg::CTRL_ADDR);
  assign wr_cur = wr_pend && (wr_addr == core_tick_timer_pkg::CURRENT_ADDR);
  assign wr_ctrl_word = core_tick_timer_pkg::merge_lanes(ctrl_word, hwdata,
                                                         wr_strb);
  assign wr_reload_word = core_tick_timer_pkg::merge_lanes(
    {{(32-COUNT_W){1'b0}}, reload}, hwdata, wr_strb);
  assign rd_ctrl_clear = take && !hwrite &&
                         (acc_word == core_tick_timer_pkg::CTRL_ADDR) &&
                         !(dbg_access && debug_master_kind);
  assign enable_rise = wr_ctrl && !enable &&
                       wr_ctrl_word[core_tick_timer_pkg::CTRL_ENABLE_BIT];
  // counting uses only the core clock and no reference clock exists, so the rate limit never applies
  assign counting = enable && !core_halted;
  assign zero_event = counting && !wr_cur && !enable_rise &&
                      (count == COUNT_ONE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable <= core_tick_timer_pkg::CTRL_BIT_RESET;
      tick_irq_enable <= core_tick_timer_pkg::CTRL_BIT_RESET;
      clock_select_bit <= core_tick_timer_pkg::CTRL_BIT_RESET;
    end else if (wr_ctrl) begin
      enable <= wr_ctrl_word[core_tick_timer_pkg::CTRL_ENABLE_BIT];
      tick_irq_enable <= wr_ctrl_word[core_tick_timer_pkg::CTRL_IRQ_EN_BIT];
      // stored only; no external reference exists to switch to
      clock_select_bit <= wr_ctrl_word[core_tick_timer_pkg::CTRL_CLKSEL_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload <= COUNT_ZERO;
    end else if (wr_pend && (wr_addr == core_tick_timer_pkg::RELOAD_ADDR)) begin
      reload <= wr_reload_word[COUNT_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= COUNT_ZERO;
    end else if (wr_cur) begin
      count <= COUNT_ZERO;
    end else if (enable_rise) begin
      count <= reload;
    end else if (counting) begin
      if (count == COUNT_ZERO) begin
        // a zero reload reloads zero, so the count parks there
        count <= reload;
      end else begin
        count <= count - COUNT_ONE;
      end
    end
  end

  // a zero in the same cycle as the clearing read wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_reached_flag <= core_tick_timer_pkg::CTRL_BIT_RESET;
    end else if (zero_event) begin
      zero_reached_flag <= 1'b1;
    end else if (rd_ctrl_clear || wr_cur) begin
      zero_reached_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_pend <= 1'b0;
    end else begin
      tick_pend <= zero_event && tick_irq_enable;
    end
  end

  always_comb begin
    next_irq_status = irq_status;
    if (wr_pend && (wr_addr == core_tick_timer_pkg::IRQ_STATUS_ADDR) &&
        wr_strb[0] && hwdata[core_tick_timer_pkg::IRQ_ZERO_BIT]) begin
      next_irq_status = 1'b0;
    end
    if (zero_event) begin
      next_irq_status = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 1'b0;
      irq_mask <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_pend && (wr_addr == core_tick_timer_pkg::IRQ_MASK_ADDR) &&
          wr_strb[0]) begin
        irq_mask <= hwdata[core_tick_timer_pkg::IRQ_ZERO_BIT];
        irq <= next_irq_status && hwdata[core_tick_timer_pkg::IRQ_ZERO_BIT];
      end else begin
        irq <= next_irq_status && irq_mask;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cur_write;
    wr_cur;
  endsequence
  sequence s_user_access;
    acc_valid && !hprot[core_tick_timer_pkg::HPROT_PRIV_BIT];
  endsequence
  sequence s_last_step;
    counting && !wr_cur && !enable_rise && (count == COUNT_ONE);
  endsequence

  a_count_decrement: assert property (
    counting && !wr_cur && !enable_rise && (count != COUNT_ZERO)
    |=> count == $past(count) - COUNT_ONE)
    else $error("count did not decrement by one");
  a_wrap_reload: assert property (
    counting && !wr_cur && !enable_rise && (count == COUNT_ZERO)
    |=> count == $past(reload))
    else $error("count did not reload after zero");
  a_zero_reload_stop: assert property (
    counting && (count == COUNT_ZERO) && (reload == COUNT_ZERO) &&
    !wr_pend |=> (count == COUNT_ZERO) [*2])
    else $error("count moved with zero reload");
  a_flag_on_zero: assert property (
    s_last_step |=> zero_reached_flag && (count == COUNT_ZERO))
    else $error("flag not set when count reached zero");
  a_flag_read_clear: assert property (
    rd_ctrl_clear && !zero_event
    |=> !zero_reached_flag &&
    hrdata[core_tick_timer_pkg::CTRL_FLAG_BIT] == $past(zero_reached_flag))
    else $error("control read left the flag set");
  a_debug_flag_keep: assert property (
    take && !hwrite && dbg_access && debug_master_kind && zero_reached_flag &&
    !wr_cur |=> zero_reached_flag)
    else $error("debugger read cleared the flag");
  a_cur_write_clear: assert property (
    s_cur_write |=> (count == COUNT_ZERO) && !zero_reached_flag && !tick_pend)
    else $error("current write did not clear count and flag");
  a_halt_hold: assert property (
    core_halted && !wr_cur && !enable_rise |=> $stable(count))
    else $error("count changed while halted");
  a_pend_gate: assert property (
    s_last_step |=> tick_pend == $past(tick_irq_enable))
    else $error("tick pend does not follow tick enable");
  a_enable_load: assert property (
    enable_rise && !wr_cur |=> enable && (count == $past(reload)))
    else $error("enable did not load the reload value");
  a_user_fault: assert property (
    s_user_access |=> (hresp && !hreadyout) ##1 (hresp && hreadyout))
    else $error("user access missed the two-cycle error");
  a_cur_read_data: assert property (
    take && !hwrite && (acc_word == core_tick_timer_pkg::CURRENT_ADDR)
    |=> hrdata[COUNT_W-1:0] == $past(count) && hreadyout && !hresp)
    else $error("current read returned a stale count");
endmodule
`default_nettype wire

/* File: core_tick_timer_pkg.sv */
/*
 core tick timer package: register byte addresses, control bit positions,
 reset values, bus encodings, bus response states and byte lane helpers.
 assumes a 32-bit little endian AHB-Lite register bus.
*/
`default_nettype none
package core_tick_timer_pkg;
  localparam logic [31:0] CTRL_ADDR = 32'hE000E010;
  localparam logic [31:0] RELOAD_ADDR = 32'hE000E014;
  localparam logic [31:0] CURRENT_ADDR = 32'hE000E018;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hE000E01C;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hE000E020;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int CTRL_CLKSEL_BIT = 2;
  localparam int CTRL_FLAG_BIT = 16;
  localparam int IRQ_ZERO_BIT = 0;

  localparam int COUNT_BITS = 24;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic CTRL_BIT_RESET = 1'b0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam int HPROT_PRIV_BIT = 1;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [3:0] STRB_BYTE0 = 4'h1;
  localparam logic [3:0] STRB_LOW_HALF = 4'h3;
  localparam logic [3:0] STRB_HIGH_HALF = 4'hC;
  localparam logic [3:0] STRB_WORD = 4'hF;

  typedef enum logic [1:0] {
    RSP_OKAY = 2'h0,
    RSP_ERR_WAIT = 2'h1,
    RSP_ERR_DONE = 2'h3
  } resp_state_t;

  function automatic logic [3:0] lane_strobes(input logic [2:0] size,
                                              input logic [1:0] addr);
    case (size)
      HSIZE_BYTE: lane_strobes = STRB_BYTE0 << addr;
      HSIZE_HALF: lane_strobes = addr[1] ? STRB_HIGH_HALF : STRB_LOW_HALF;
      default: lane_strobes = STRB_WORD;
    endcase
  endfunction

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return merged;
  endfunction
endpackage
`default_nettype wire

/* File: core_tick_timer_tb_top.sv */
/*
 core tick timer testbench: drives the AHB-Lite register port directly and
 judges counter, flag, interrupt and bus answers.
 assumes zero-wait OKAY answers, a two-cycle ERROR answer, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module core_tick_timer_tb_top;
  logic hclk, hresetn, hsel, hwrite, dbg_access, debug_master_kind;
  logic core_halted, hreadyout, hresp, tick_pend, irq, hready, priv, er;
  logic [31:0] haddr, hwdata, hrdata, rv, p0, data_s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] hprot;
  logic rdy_s, resp_s, tp_s;
  int bad_count = 0, num_checks = 0, cyc = 0, last = 0, gap = 0, pulses = 0;
  int n0;

  assign hready = hreadyout;
  core_tick_timer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hprot(hprot), .hwdata(hwdata), .hready(hready),
    .dbg_access(dbg_access), .debug_master_kind(debug_master_kind),
    .core_halted(core_halted), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tick_pend(tick_pend), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // values latched mid-cycle, so the rising edge sees them race-free
  always @(negedge hclk) begin
    rdy_s <= hready;
    resp_s <= hresp;
    data_s <= hrdata;
    tp_s <= tick_pend;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (tp_s === 1'b1) begin
      pulses <= pulses + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // entered just after a rising edge; waits on hready with no fixed latency
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= core_tick_timer_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    hprot <= {2'b00, priv, 1'b1};
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    chk({31'h0, rdy_s}, 32'h1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    chk({31'h0, rdy_s}, 32'h1);
    rv = data_s;
    er = resp_s;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
    chk({31'h0, er}, 32'h0);
  endtask

  // irq is registered from the next status and mask values, in step with them
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge hclk);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(core_tick_timer_pkg::CTRL_ADDR + 32'(4 * i));
      chk(rv, core_tick_timer_pkg::WORD_ZERO);
    end
    irq_is(1'b0);
  endtask

  task automatic t_period();
    wr(core_tick_timer_pkg::RELOAD_ADDR, 32'h00000004);
    wr(core_tick_timer_pkg::IRQ_MASK_ADDR, 32'h00000001);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000007);
    repeat (30) @(posedge hclk);
    chk(32'(gap), 32'h00000005);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000005);
    repeat (8) @(posedge hclk);
    n0 = pulses;
    repeat (20) @(posedge hclk);
    chk(32'(pulses - n0), 32'h0);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000000);
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00010000);
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00000000);
    irq_is(1'b1);
    wr(core_tick_timer_pkg::IRQ_MASK_ADDR, 32'h00000000);
    irq_is(1'b0);
    wr(core_tick_timer_pkg::IRQ_MASK_ADDR, 32'h00000001);
    irq_is(1'b1);
    wr(core_tick_timer_pkg::IRQ_STATUS_ADDR, 32'h00000001);
    irq_is(1'b0);
    rd(core_tick_timer_pkg::IRQ_STATUS_ADDR);
    chk(rv, 32'h00000000);
  endtask

  task automatic t_current();
    wr(core_tick_timer_pkg::RELOAD_ADDR, 32'h00FFFFFF);
    rd(core_tick_timer_pkg::RELOAD_ADDR);
    chk(rv, 32'h00FFFFFF);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000005);
    rd(core_tick_timer_pkg::CURRENT_ADDR);
    p0 = rv;
    rd(core_tick_timer_pkg::CURRENT_ADDR);
    chk(p0 - rv, 32'h00000002);
    core_halted <= 1'b1;
    rd(core_tick_timer_pkg::CURRENT_ADDR);
    p0 = rv;
    rd(core_tick_timer_pkg::CURRENT_ADDR);
    chk(rv, p0);
    core_halted <= 1'b0;
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000000);
  endtask

  task automatic t_zero_reload();
    wr(core_tick_timer_pkg::RELOAD_ADDR, 32'h00000002);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000007);
    repeat (10) @(posedge hclk);
    wr(core_tick_timer_pkg::RELOAD_ADDR, 32'h00000000);
    repeat (10) @(posedge hclk);
    n0 = pulses;
    repeat (20) @(posedge hclk);
    chk(32'(pulses - n0), 32'h0);
    rd(core_tick_timer_pkg::CURRENT_ADDR);
    chk(rv, 32'h00000000);
    wr(core_tick_timer_pkg::CURRENT_ADDR, 32'h12345678);
    // a read overlapping the write's data phase would see the old flag
    @(posedge hclk);
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00000007);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000000);
  endtask

  task automatic t_debug();
    wr(core_tick_timer_pkg::RELOAD_ADDR, 32'h00000002);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000005);
    repeat (6) @(posedge hclk);
    wr(core_tick_timer_pkg::CTRL_ADDR, 32'h00000000);
    dbg_access <= 1'b1;
    debug_master_kind <= 1'b1;
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00010000);
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00010000);
    debug_master_kind <= 1'b0;
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00010000);
    rd(core_tick_timer_pkg::CTRL_ADDR);
    chk(rv, 32'h00000000);
    dbg_access <= 1'b0;
  endtask

  task automatic t_priv();
    wr(core_tick_timer_pkg::RELOAD_ADDR, 32'h00000003);
    // blocking: bus() reads priv in this same time step
    priv = 1'b0;
    bus(1'b1, core_tick_timer_pkg::RELOAD_ADDR, 32'h00000007);
    chk({31'h0, er}, 32'h1);
    bus(1'b0, core_tick_timer_pkg::RELOAD_ADDR, 32'h0);
    chk({rv[30:0], er}, 32'h1);
    priv = 1'b1;
    rd(core_tick_timer_pkg::RELOAD_ADDR);
    chk(rv, 32'h00000003);
    rd(32'hE000E030);
    chk(rv, 32'h00000000);
  endtask

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hprot = 4'h3;
    hwdata = 32'h0;
    dbg_access = 1'b0;
    debug_master_kind = 1'b0;
    core_halted = 1'b0;
    priv = 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_period();
    t_current();
    t_zero_reload();
    t_debug();
    t_priv();
    conclude();
  end
endmodule
`default_nettype wire
